// file: design/standby_pkg.sv
// Constants, register map and types for the standby power-saving control block.
package standby_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] FSEL0_OFF = 8'h00;
   localparam logic [ADDR_W-1:0] FSEL1_OFF = 8'h04;
   localparam logic [ADDR_W-1:0] ADC_CTRL1_OFF = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_PORT_DATA_OFF = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_PORT_DIR_OFF = 8'h10;
   localparam logic [ADDR_W-1:0] DATA_PORT_DATA_OFF = 8'h14;
   localparam logic [ADDR_W-1:0] DATA_PORT_DIR_OFF = 8'h18;
   localparam logic [ADDR_W-1:0] CTL_PORT_DATA_OFF = 8'h1c;
   localparam logic [ADDR_W-1:0] CTL_PORT_DIR_OFF = 8'h20;
   localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h24;
   localparam int FSEL0_STOP_IGNORE_BIT = 0;
   localparam int FSEL0_EXT_CLK_BIT = 1;
   localparam int FSEL1_STOP_FLAG_BIT = 0;
   localparam int FSEL1_WAIT_FLAG_BIT = 1;
   localparam int FSEL1_PIN_RELEASE_BIT = 2;
   localparam int FSEL1_PERIPH_STOP_BIT = 3;
   localparam int ADC1_REF_DISC_BIT = 6;
   localparam int CTL_RD_BIT = 0;
   localparam int CTL_BLW_BIT = 1;
   localparam int CTL_BHW_BIT = 2;
   localparam int CTL_CS0_BIT = 3;
   localparam int STATUS_RELEASED_BIT = 2;
   localparam int STATUS_BYTE_MODE_BIT = 3;
   localparam int STATUS_REF_READY_BIT = 4;
   localparam int STATUS_PIN_LSB = 16;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int REF_SETTLE_NS = 1000;
   localparam int REF_SETTLE_CYCLES = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STAB_CYCLES_DEFAULT = 4096;
   localparam int TIMER_W = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAIT, ST_STAB} power_state_e;
endpackage

// file: design/timer_if.sv
// Start and completion signals between the control block and a cycle timer.
`timescale 1ns/1ns
interface timer_if;
   import standby_pkg::*;
   logic start;
   logic [TIMER_W-1:0] load;
   logic busy;
   logic done;
   modport ctrl (output start, output load, input busy, input done);
   modport timer (input start, input load, output busy, output done);
endinterface

// file: design/cycle_timer.sv
// Down counter that runs for a loaded number of cycles and pulses done at the end.
`timescale 1ns/1ns
module cycle_timer
   import standby_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   timer_if.timer tif
);
   logic [TIMER_W-1:0] count_reg;
   logic busy_reg;
   logic done_reg;

   assign tif.busy = busy_reg;
   assign tif.done = done_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else if (tif.start)
      begin
         count_reg <= tif.load;
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
      end
      else if (busy_reg && count_reg <= 16'h0001)
      begin
         count_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b1;
      end
      else
      begin
         count_reg <= busy_reg ? count_reg - 16'h0001 : count_reg;
         done_reg <= 1'b0;
      end
   end
endmodule

// file: design/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] pin_async,
   output logic [W-1:0] pin_synced
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   assign pin_synced = sync_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= pin_async;
         sync_reg <= meta_reg;
      end
   end
endmodule

// file: design/standby_power_ctrl.sv
// Standby power-saving control: bus pin release, clock gating, oscillator and reference control.
// Behaviour
// - Release bit set: bus and strobe pins become port pins during stop or wait.
// - Released pins take level and direction from port data and direction registers.
// - Release applies only in standby; with the bit clear pins keep bus function, except those held as port pins in 8-bit mode.
// - Leaving standby restores bus and strobe functions on every released pin not held as a port pin in 8-bit mode.
// - Address 0-7 to port 10, 8-15 to port 11, 16-23 to port 0.
// - Data 0-7 to port 1, data 8-15 to port 2.
// - Read strobe P3.1, low write P3.2, high write P3.3, chip select P9.0.
// - In 8-bit bus mode data 8-15 and high write strobe are always port pins.
// - Wait with peripheral clock-stop bit set stops all peripheral clocks.
// - External-clock bit set disables the oscillator driver.
// - With the driver disabled for external clock the oscillator output is held high.
// - External-clock mode skips the stabilisation wait when an interrupt ends stop.
// - Reference-disconnect bit set disconnects the converter ladder from the reference.
// - Stop ends on an accepted interrupt or reset, then oscillation restarts.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ns
module standby_power_ctrl
   import standby_pkg::*;
#(
   parameter int STAB_CYCLES = STAB_CYCLES_DEFAULT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic stop_request,
   input wire logic wait_request,
   input wire logic irq_accept,
   input wire logic byte_width_pin,
   input wire logic [23:0] bus_addr,
   input wire logic [15:0] bus_data_out,
   input wire logic [15:0] bus_data_oe,
   input wire logic [3:0] bus_ctl,
   output logic [23:0] addr_pin_out,
   output logic [23:0] addr_pin_oe,
   output logic [15:0] data_pin_out,
   output logic [15:0] data_pin_oe,
   input wire logic [15:0] data_pin_in,
   output logic [3:0] ctl_pin_out,
   output logic [3:0] ctl_pin_oe,
   output logic stop_standby,
   output logic wait_standby,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_drive_en,
   output logic osc_out_pin,
   output logic ladder_connect
);
   logic [31:0] fsel0_reg;
   logic [31:0] fsel1_reg;
   logic [31:0] adc1_reg;
   logic [23:0] addr_port_data_reg;
   logic [23:0] addr_port_dir_reg;
   logic [15:0] data_port_data_reg;
   logic [15:0] data_port_dir_reg;
   logic [3:0] ctl_port_data_reg;
   logic [3:0] ctl_port_dir_reg;
   power_state_e state_reg;
   power_state_e state_next;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [ADDR_W-1:0] wr_addr_reg;
   logic [31:0] wr_data_reg;
   logic [3:0] wr_strb_reg;
   logic do_write;
   logic [16:0] synced;
   logic byte_mode;
   logic [15:0] data_pin_level;
   logic stop_enter;
   logic released_next;
   logic released_reg;
   logic [15:0] data_port_sel;
   logic [3:0] ctl_port_sel;
   logic [23:0] addr_pin_out_reg;
   logic [23:0] addr_pin_oe_reg;
   logic [15:0] data_pin_out_reg;
   logic [15:0] data_pin_oe_reg;
   logic [3:0] ctl_pin_out_reg;
   logic [3:0] ctl_pin_oe_reg;
   logic stop_standby_reg;
   logic wait_standby_reg;
   logic cpu_clk_en_reg;
   logic periph_clk_en_reg;
   logic osc_drive_en_reg;
   logic osc_out_pin_reg;
   logic ladder_connect_reg;
   logic ref_restart;

   timer_if stab_tif ();
   timer_if ref_tif ();

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      addr_ok = (a == FSEL0_OFF) || (a == FSEL1_OFF) || (a == ADC_CTRL1_OFF) ||
                (a == ADDR_PORT_DATA_OFF) || (a == ADDR_PORT_DIR_OFF) ||
                (a == DATA_PORT_DATA_OFF) || (a == DATA_PORT_DIR_OFF) ||
                (a == CTL_PORT_DATA_OFF) || (a == CTL_PORT_DIR_OFF) || (a == STATUS_OFF);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      merge = res;
   endfunction

   function automatic logic [23:0] pick(input logic [23:0] sel, input logic [23:0] port_val,
                                        input logic [23:0] bus_val);
      pick = (port_val & sel) | (bus_val & ~sel);
   endfunction

   pin_sync #(.W(17)) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_async({byte_width_pin, data_pin_in}),
      .pin_synced(synced)
   );

   assign byte_mode = synced[16];
   assign data_pin_level = synced[15:0];

   cycle_timer u_stab_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .tif(stab_tif)
   );

   cycle_timer u_ref_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .tif(ref_tif)
   );

   // Bus slave: write address and data are held until both are present.
   assign do_write = !awready_reg && !wready_reg && !bvalid_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
         wr_strb_reg <= '0;
      end
      else
      begin
         if (awvalid && awready_reg)
         begin
            awready_reg <= 1'b0;
            wr_addr_reg <= awaddr;
         end
         if (wvalid && wready_reg)
         begin
            wready_reg <= 1'b0;
            wr_data_reg <= wdata;
            wr_strb_reg <= wstrb;
         end
         if (do_write)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_ok(wr_addr_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_reg && bready)
         begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // Bus slave: read data come from the register named by the address.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end
      else if (arvalid && arready_reg)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
         if (araddr == FSEL0_OFF)
            rdata_reg <= fsel0_reg;
         else if (araddr == FSEL1_OFF)
            rdata_reg <= fsel1_reg;
         else if (araddr == ADC_CTRL1_OFF)
            rdata_reg <= adc1_reg;
         else if (araddr == ADDR_PORT_DATA_OFF)
            rdata_reg <= {8'h00, addr_port_data_reg};
         else if (araddr == ADDR_PORT_DIR_OFF)
            rdata_reg <= {8'h00, addr_port_dir_reg};
         else if (araddr == DATA_PORT_DATA_OFF)
            rdata_reg <= {16'h0000, data_port_data_reg};
         else if (araddr == DATA_PORT_DIR_OFF)
            rdata_reg <= {16'h0000, data_port_dir_reg};
         else if (araddr == CTL_PORT_DATA_OFF)
            rdata_reg <= {28'h0000000, ctl_port_data_reg};
         else if (araddr == CTL_PORT_DIR_OFF)
            rdata_reg <= {28'h0000000, ctl_port_dir_reg};
         else if (araddr == STATUS_OFF)
            rdata_reg <= {data_pin_level, 11'h000, !ref_tif.busy, byte_mode, released_reg,
                          state_reg};
         else
            rdata_reg <= '0;
      end
      else if (rvalid_reg && rready)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // Select registers; hardware setting of the standby flags wins over a clear.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fsel0_reg <= REG_RESET;
         fsel1_reg <= REG_RESET;
         adc1_reg <= REG_RESET;
      end
      else
      begin
         if (do_write && wr_addr_reg == FSEL0_OFF)
            fsel0_reg <= merge(fsel0_reg, wr_data_reg, wr_strb_reg) & 32'h0000_0003;
         if (do_write && wr_addr_reg == FSEL1_OFF)
            fsel1_reg <= merge(fsel1_reg, wr_data_reg, wr_strb_reg) & 32'h0000_000f;
         if (stop_enter)
            fsel1_reg[FSEL1_STOP_FLAG_BIT] <= 1'b1;
         if (state_reg == ST_RUN && state_next == ST_WAIT)
            fsel1_reg[FSEL1_WAIT_FLAG_BIT] <= 1'b1;
         if (do_write && wr_addr_reg == ADC_CTRL1_OFF)
            adc1_reg <= merge(adc1_reg, wr_data_reg, wr_strb_reg) & 32'h0000_00ff;
      end
   end

   // Port data and direction registers for the released pins.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         addr_port_data_reg <= '0;
         addr_port_dir_reg <= '0;
         data_port_data_reg <= '0;
         data_port_dir_reg <= '0;
         ctl_port_data_reg <= '0;
         ctl_port_dir_reg <= '0;
      end
      else if (do_write)
      begin
         if (wr_addr_reg == ADDR_PORT_DATA_OFF)
            addr_port_data_reg <= 24'(merge({8'h00, addr_port_data_reg}, wr_data_reg, wr_strb_reg));
         else if (wr_addr_reg == ADDR_PORT_DIR_OFF)
            addr_port_dir_reg <= 24'(merge({8'h00, addr_port_dir_reg}, wr_data_reg, wr_strb_reg));
         else if (wr_addr_reg == DATA_PORT_DATA_OFF)
            data_port_data_reg <= 16'(merge({16'h0000, data_port_data_reg}, wr_data_reg,
                                            wr_strb_reg));
         else if (wr_addr_reg == DATA_PORT_DIR_OFF)
            data_port_dir_reg <= 16'(merge({16'h0000, data_port_dir_reg}, wr_data_reg,
                                           wr_strb_reg));
         else if (wr_addr_reg == CTL_PORT_DATA_OFF)
            ctl_port_data_reg <= 4'(merge({28'h0000000, ctl_port_data_reg}, wr_data_reg,
                                          wr_strb_reg));
         else if (wr_addr_reg == CTL_PORT_DIR_OFF)
            ctl_port_dir_reg <= 4'(merge({28'h0000000, ctl_port_dir_reg}, wr_data_reg,
                                         wr_strb_reg));
      end
   end

   // Standby state machine.
   assign stop_enter = state_reg == ST_RUN && stop_request && !fsel0_reg[FSEL0_STOP_IGNORE_BIT];

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN:
         begin
            if (stop_enter)
               state_next = ST_STOP;
            else if (wait_request)
               state_next = ST_WAIT;
         end
         ST_STOP:
         begin
            if (irq_accept)
               state_next = fsel0_reg[FSEL0_EXT_CLK_BIT] ? ST_RUN : ST_STAB;
         end
         ST_WAIT:
         begin
            if (irq_accept)
               state_next = ST_RUN;
         end
         ST_STAB:
         begin
            if (stab_tif.done)
               state_next = ST_RUN;
         end
         default:
            state_next = ST_RUN;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_reg <= ST_RUN;
      else
         state_reg <= state_next;
   end

   assign stab_tif.start = state_reg == ST_STOP && state_next == ST_STAB;
   assign stab_tif.load = TIMER_W'(STAB_CYCLES);

   // Reference settle timer restarts whenever the reference is reconnected.
   assign ref_restart = do_write && wr_addr_reg == ADC_CTRL1_OFF && wr_strb_reg[0] &&
                        adc1_reg[ADC1_REF_DISC_BIT] && !wr_data_reg[ADC1_REF_DISC_BIT];
   assign ref_tif.start = ref_restart;
   assign ref_tif.load = TIMER_W'(REF_SETTLE_CYCLES);

   // Pin function selection, taken from the next state so it moves with the state.
   assign released_next = (state_next == ST_STOP || state_next == ST_WAIT) &&
                          fsel1_reg[FSEL1_PIN_RELEASE_BIT];
   assign data_port_sel = {{8{released_next || byte_mode}}, {8{released_next}}};
   assign ctl_port_sel = {released_next, released_next || byte_mode, released_next,
                          released_next};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         released_reg <= 1'b0;
         addr_pin_out_reg <= '0;
         addr_pin_oe_reg <= '1;
         data_pin_out_reg <= '0;
         data_pin_oe_reg <= '0;
         ctl_pin_out_reg <= '1;
         ctl_pin_oe_reg <= '1;
      end
      else
      begin
         released_reg <= released_next;
         // Address 0-7 port 10, 8-15 port 11, 16-23 port 0.
         addr_pin_out_reg <= pick({24{released_next}}, addr_port_data_reg, bus_addr);
         addr_pin_oe_reg <= pick({24{released_next}}, addr_port_dir_reg, 24'hff_ffff);
         // Data 0-7 port 1, 8-15 port 2.
         data_pin_out_reg <= 16'(pick({8'h00, data_port_sel}, {8'h00, data_port_data_reg},
                                      {8'h00, bus_data_out}));
         data_pin_oe_reg <= 16'(pick({8'h00, data_port_sel}, {8'h00, data_port_dir_reg},
                                     {8'h00, bus_data_oe}));
         ctl_pin_out_reg <= 4'(pick({20'h00000, ctl_port_sel}, {20'h00000, ctl_port_data_reg},
                                    {20'h00000, bus_ctl}));
         ctl_pin_oe_reg <= 4'(pick({20'h00000, ctl_port_sel}, {20'h00000, ctl_port_dir_reg},
                                   24'h00000f));
      end
   end

   // Clock, oscillator and reference controls.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stop_standby_reg <= 1'b0;
         wait_standby_reg <= 1'b0;
         cpu_clk_en_reg <= 1'b1;
         periph_clk_en_reg <= 1'b1;
         osc_drive_en_reg <= 1'b1;
         osc_out_pin_reg <= 1'b0;
         ladder_connect_reg <= 1'b1;
      end
      else
      begin
         stop_standby_reg <= state_next == ST_STOP;
         wait_standby_reg <= state_next == ST_WAIT;
         cpu_clk_en_reg <= state_next == ST_RUN;
         periph_clk_en_reg <= !(state_next == ST_STOP || (state_next == ST_WAIT &&
                               fsel1_reg[FSEL1_PERIPH_STOP_BIT]));
         osc_drive_en_reg <= !fsel0_reg[FSEL0_EXT_CLK_BIT] &&
                             state_next != ST_STOP;
         osc_out_pin_reg <= fsel0_reg[FSEL0_EXT_CLK_BIT];
         ladder_connect_reg <= !adc1_reg[ADC1_REF_DISC_BIT];
      end
   end

   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign addr_pin_out = addr_pin_out_reg;
   assign addr_pin_oe = addr_pin_oe_reg;
   assign data_pin_out = data_pin_out_reg;
   assign data_pin_oe = data_pin_oe_reg;
   assign ctl_pin_out = ctl_pin_out_reg;
   assign ctl_pin_oe = ctl_pin_oe_reg;
   assign stop_standby = stop_standby_reg;
   assign wait_standby = wait_standby_reg;
   assign cpu_clk_en = cpu_clk_en_reg;
   assign periph_clk_en = periph_clk_en_reg;
   assign osc_drive_en = osc_drive_en_reg;
   assign osc_out_pin = osc_out_pin_reg;
   assign ladder_connect = ladder_connect_reg;
endmodule

// file: test/standby_monitor.sv
// Port checker for the standby power-saving control block.
`timescale 1ns/1ns
module standby_monitor #(
   parameter int STAB_CYCLES = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic stop_request,
   input wire logic irq_accept,
   input wire logic [23:0] bus_addr,
   input wire logic [23:0] addr_pin_out,
   input wire logic stop_standby,
   input wire logic wait_standby,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_drive_en,
   input wire logic osc_out_pin
);
   localparam int STAB_MAX = STAB_CYCLES + 2;
   logic idle;
   assign idle = !stop_standby && !wait_standby;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence exit_stop;
      $fell(stop_standby) ##0 !cpu_clk_en;
   endsequence
   sequence stab_hold;
      !cpu_clk_en [*2];
   endsequence
   bus_follow_a: assert property ($past(aresetn) && idle && $past(idle) |->
      addr_pin_out == $past(bus_addr)) else $error("Address pins left bus function.");
   stop_gate_a: assert property (stop_standby |->
      !cpu_clk_en && !periph_clk_en && !osc_drive_en) else $error("Clocks run in stop.");
   wait_cpu_a: assert property (wait_standby |-> !cpu_clk_en)
      else $error("Processor clock runs in wait.");
   one_state_a: assert property (!(stop_standby && wait_standby))
      else $error("Stop and wait both active.");
   osc_high_a: assert property (osc_out_pin |-> !osc_drive_en)
      else $error("Oscillator output high while driver on.");
   stop_cause_a: assert property ($rose(stop_standby) |-> $past(stop_request))
      else $error("Stop entered without request.");
   wait_exit_a: assert property ($fell(wait_standby) |-> $past(irq_accept))
      else $error("Wait left without interrupt.");
   stop_exit_a: assert property ($fell(stop_standby) |-> $past(irq_accept))
      else $error("Stop left without interrupt.");
   stab_wait_a: assert property (exit_stop |-> stab_hold ##[1:STAB_MAX] cpu_clk_en)
      else $error("Stabilisation wait wrong length.");
   fast_wake_a: assert property ($fell(stop_standby) && osc_out_pin |-> cpu_clk_en)
      else $error("External clock wake was delayed.");
endmodule
bind standby_power_ctrl standby_monitor #(.STAB_CYCLES(STAB_CYCLES)) i_standby_monitor (.aclk,
   .aresetn, .stop_request, .irq_accept, .bus_addr, .addr_pin_out, .stop_standby, .wait_standby,
   .cpu_clk_en, .periph_clk_en, .osc_drive_en, .osc_out_pin);

// file: test/ext_mem_model.sv
// Behavioural external memory on the parallel data bus.
`timescale 1ns/1ns
module ext_mem_model (
   input wire logic aclk,
   input wire logic [15:0] data_pin_out,
   input wire logic [15:0] data_pin_oe,
   input wire logic [3:0] ctl_pin_out,
   input wire logic [3:0] ctl_pin_oe,
   output logic [15:0] data_pin_in
);
   logic mem_drive;
   assign mem_drive = &ctl_pin_oe[3:0] && !ctl_pin_out[0] && !ctl_pin_out[3];
   assign data_pin_in = (data_pin_oe & data_pin_out) |
      (~data_pin_oe & (mem_drive ? 16'hc35a : ~data_pin_out));
endmodule

// file: test/testbench.sv
// Self-checking testbench for the standby power-saving control block.
`timescale 1ns/1ns
module testbench
   import standby_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stop_request, wait_request;
   logic irq_accept, byte_width_pin, awready, wready, bvalid, arready, rvalid, stop_standby;
   logic wait_standby, cpu_clk_en, periph_clk_en, osc_drive_en, osc_out_pin, ladder_connect;
   logic rel, st;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0] wstrb, bus_ctl, ctl_pin_out, ctl_pin_oe;
   logic [1:0] bresp, rresp, rd_resp, wr_resp;
   logic [23:0] bus_addr, addr_pin_out, addr_pin_oe;
   logic [15:0] bus_data_out, bus_data_oe, data_pin_out, data_pin_oe, data_pin_in;
   int failures, tests_run, cyc;
   standby_power_ctrl #(.STAB_CYCLES(8)) i_standby_power_ctrl (.*);
   ext_mem_model i_ext_mem_model (.*);
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      wr_resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd_val = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic enter(input logic s);
      @(posedge aclk);
      stop_request <= s;
      wait_request <= !s;
      @(posedge aclk);
      stop_request <= 1'b0;
      wait_request <= 1'b0;
      @(negedge aclk);
   endtask
   task automatic wake;
      @(posedge aclk);
      irq_accept <= 1'b1;
      @(posedge aclk);
      irq_accept <= 1'b0;
      @(negedge aclk);
   endtask
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial
   begin
      cyc = 0;
      forever
      begin
         @(posedge aclk);
         cyc++;
         if (cyc == 5000)
         begin
            failures++;
            $display("MISMATCH t=%0t run did not finish", $time);
            report_and_stop;
         end
      end
   end
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {stop_request, wait_request, irq_accept, byte_width_pin} = '0;
      {awaddr, araddr, awprot, arprot, wdata, bus_data_out, bus_data_oe} = '0;
      wstrb = 4'hf;
      bus_ctl = 4'ha;
      bus_addr = 24'h123456;
      failures = 0;
      tests_run = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(FSEL0_OFF);
      chk(rd_val, 32'h0);
      rd(FSEL1_OFF);
      chk(rd_val, 32'h0);
      rd(ADC_CTRL1_OFF);
      chk(rd_val, 32'h0);
      chk({ladder_connect, osc_drive_en, osc_out_pin, cpu_clk_en, periph_clk_en},
         5'h1b);
      rd(8'hfc);
      chk(rd_resp, RESP_SLVERR);
      wr(8'hfc, 32'h1);
      chk(wr_resp, RESP_SLVERR);
      wr(ADDR_PORT_DATA_OFF, 32'h00a5c3e1);
      wr(ADDR_PORT_DIR_OFF, 32'h000f0f0f);
      wr(DATA_PORT_DATA_OFF, 32'h00001234);
      wr(DATA_PORT_DIR_OFF, 32'h00000fff);
      wr(CTL_PORT_DATA_OFF, 32'h00000005);
      wr(CTL_PORT_DIR_OFF, 32'h00000006);
      for (int m = 0; m < 4; m++)
      begin
         rel = m[0];
         st = m[1];
         wr(FSEL1_OFF, {28'h0, rel, rel, 2'b00});
         enter(st);
         chk({stop_standby, wait_standby}, {st, !st});
         chk(periph_clk_en, !(st || rel));
         chk({ctl_pin_out, ctl_pin_oe, data_pin_oe, addr_pin_out},
            rel ? {4'h5, 4'h6, 16'h0fff, 24'ha5c3e1} :
            {4'ha, 4'hf, 16'h0, 24'h123456});
         chk({addr_pin_oe, data_pin_out[7:0]},
            rel ? 32'h0f0f0f34 : 32'hffffff00);
         wake;
         chk({stop_standby, wait_standby, addr_pin_out}, {2'b00, 24'h123456});
         rd(FSEL1_OFF);
         chk(rd_val, {28'h0, rel, rel, !st, st});
         repeat (12) @(negedge aclk);
         chk(cpu_clk_en, 1'b1);
         wr(FSEL1_OFF, 32'h0);
      end
      byte_width_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      chk({data_pin_oe[15:8], data_pin_out[15:8], ctl_pin_out[2], ctl_pin_oe[2]},
         18'h03c4b);
      @(posedge aclk) byte_width_pin <= 1'b0;
      wr(FSEL0_OFF, 32'h1);
      enter(1'b1);
      chk({stop_standby, cpu_clk_en}, 2'b01);
      wr(FSEL0_OFF, 32'h2);
      @(negedge aclk);
      chk({osc_drive_en, osc_out_pin}, 2'b01);
      enter(1'b1);
      wake;
      chk(cpu_clk_en, 1'b1);
      wr(ADC_CTRL1_OFF, 32'h40);
      @(negedge aclk);
      chk(ladder_connect, 1'b0);
      wr(ADC_CTRL1_OFF, 32'h0);
      rd(STATUS_OFF);
      chk(rd_val[STATUS_REF_READY_BIT], 1'b0);
      bus_ctl <= 4'h2;
      repeat (REF_SETTLE_CYCLES + 1) @(posedge aclk);
      rd(STATUS_OFF);
      chk({ladder_connect, rd_val}, {1'b1, 32'hc35a0010});
      report_and_stop;
   end
endmodule
